// ==== design/ita_top.sv ====
// ita_top: trap and interrupt acceptance for a 16-bit cpu core
// assumes the core reports instruction boundaries and takes a push/vector sequence
`timescale 1ns/100ps
`default_nettype none
module ita_top
    import ita_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic [1:0] int_mode,
    input wire logic [NUM_SRC*LVL_W-1:0] interrupt_priority_reg,
    input wire logic [NUM_SRC-1:0] src_enable,
    // request sources
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic nmi_event,
    // core status
    input wire logic instr_done,
    input wire logic trap_always_instr,
    input wire logic [TRAP_W-1:0] trap_vec_num,
    input wire logic [31:0] next_pc,
    input wire logic [7:0] ccr_in,
    input wire logic [7:0] exr_in,
    input wire logic core_ack,
    // exception sequence outputs
    output logic exc_busy,
    output logic push_valid,
    output logic [31:0] push_data,
    output logic vec_valid,
    output logic [VEC_W-1:0] vec_num,
    output logic ccr_we,
    output logic [7:0] condition_code_reg,
    output logic exr_we,
    output logic [7:0] extended_control_reg,
    output logic [NUM_SRC-1:0] src_taken
);
    ////////////////////////////////////////////////////////////////////////////
    // request gating and arbitration
    ita_arb_if arb_bus();
    ita_state_type state;             // sequencer state
    logic [1:0] push_idx;              // which word is being pushed
    logic nmi_pend;                    // latched non-maskable request
    logic [NUM_SRC-1:0] pend;          // latched enabled requests
    logic is_trap;                     // current exception is a trap
    logic is_nmi;                      // current exception is non-maskable
    logic [2:0] take_src;              // accepted source index
    logic [LVL_W-1:0] take_lvl;        // accepted source level
    logic [TRAP_W-1:0] take_trap;      // captured trap vector number
    logic [31:0] save_pc;              // resume address
    logic [7:0] save_ccr;              // ccr at entry
    logic [7:0] save_exr;              // exr at entry
    logic [LVL_W-1:0] mask_level_field; // current mask from exr
    logic irq_ok;                      // maskable request beats mask
    logic [NUM_SRC-1:0] clr_vec;       // one-hot clear of accepted source
    logic [2:0] nmi_sync;              // pin stages, [0] is the first
    logic nmi_lvl;                     // filtered pin level
    logic nmi_rise;                    // settled rising edge of the pin

    assign mask_level_field = exr_in[LVL_W-1:0];
    assign arb_bus.pend = pend;
    assign arb_bus.prio = interrupt_priority_reg;

    // winner selection lives in its own module
    ita_arbiter u_arb (
        .arb(arb_bus)
    );

    // mode 2 compares level with mask; mode 0 uses the ccr mask bit
    // mode 0 levels only pick the winner: the ccr bit masks every maskable source
    always_comb begin
        if (int_mode == MODE2) begin
            irq_ok = arb_bus.found && (arb_bus.win_lvl > mask_level_field); // strict
        end else begin
            irq_ok = arb_bus.found && !ccr_in[CCR_I];
        end
    end

    // clear pattern for the source being taken
    // stands through wait, so a repeated event is cleared again unless it lands on the last wait edge
    always_comb begin
        clr_vec = '0;
        if (state == ITA_WAIT && !is_trap && !is_nmi) begin
            clr_vec[take_src] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending flags: set wins over clear so an event on a clearing edge still sets the flag
    // source enables gate events before they reach the flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~clr_vec) | (src_event & src_enable); // enable gates
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // non-maskable pin: three stages against metastability
    // the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_sync <= '0;
        end else begin
            nmi_sync <= {nmi_sync[1:0], nmi_event};
        end
    end

    // level moves only once stages two and three agree, so a glitch
    // shorter than two clocks is dropped; the cost is a few clocks of delay
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_lvl <= 1'b0;
        end else if (nmi_sync[1] == nmi_sync[2]) begin
            nmi_lvl <= nmi_sync[2];
        end
    end

    // one pulse per settled rising edge
    assign nmi_rise = (nmi_sync[1] == nmi_sync[2]) && nmi_sync[2] && !nmi_lvl;

    // non-maskable latch, cleared when taken unless a new edge arrives
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_pend <= 1'b0;
        end else if (nmi_rise) begin
            nmi_pend <= 1'b1;
        end else if (state == ITA_WAIT && is_nmi) begin
            nmi_pend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // exception sequencer
    // idle, wait for the boundary, push three words, vector, one done cycle
    // one request is taken per pass; other nmi and maskable requests stay in their flags
    // kind flags clear with state so no stale kind survives reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ITA_IDLE;
            is_trap <= 1'b0;
            is_nmi <= 1'b0;
            take_src <= '0;
            take_lvl <= '0;
            take_trap <= '0;
        end else begin
            case (state)
                ITA_IDLE: begin
                    // trap is an instruction, so it can always enter
                    if (trap_always_instr) begin
                        is_trap <= 1'b1;
                        is_nmi <= 1'b0;
                        take_trap <= trap_vec_num; // vector 0..3
                        state <= ITA_WAIT;
                    end else if (nmi_pend) begin
                        // non-maskable outranks every maskable source
                        is_trap <= 1'b0;
                        is_nmi <= 1'b1;
                        state <= ITA_WAIT;
                    end else if (irq_ok) begin
                        // index and level frozen here, the arbiter may move on
                        is_trap <= 1'b0;
                        is_nmi <= 1'b0;
                        take_src <= arb_bus.win;
                        take_lvl <= arb_bus.win_lvl;
                        state <= ITA_WAIT;
                    end
                end
                ITA_WAIT: begin
                    // hold until the running instruction retires
                    if (instr_done) begin
                        state <= ITA_PUSH;
                    end
                end
                ITA_PUSH: begin
                    // one ack per stacked word
                    if (core_ack && push_idx == 2'(PUSH_WORDS-1)) begin
                        state <= ITA_VEC;
                    end
                end
                ITA_VEC: begin
                    // vector handed over, new ccr follows next cycle, with exr only in mode 2
                    if (core_ack) begin
                        state <= ITA_DONE;
                    end
                end
                ITA_DONE: begin
                    // spare cycle lets the write pulses land before idle
                    state <= ITA_IDLE;
                end
                default: begin
                    state <= ITA_IDLE;
                end
            endcase
        end
    end

    // capture context at the instruction boundary
    // sampled once, so later core changes cannot leak into the stack
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            save_pc <= '0;
            save_ccr <= '0;
            save_exr <= '0;
        end else if (state == ITA_WAIT && instr_done) begin
            save_pc <= next_pc; // resume address is the next instruction
            save_ccr <= ccr_in;
            save_exr <= exr_in;
        end
    end

    // push word counter
    // cleared outside push, so every exception starts at the pc word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_idx <= '0;
        end else if (state != ITA_PUSH) begin
            push_idx <= '0;
        end else if (core_ack) begin
            push_idx <= push_idx + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: stack words, vector and new ccr/exr
    // next word is loaded ahead, so data stands whenever push_valid does
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_data <= '0;
        end else if (state == ITA_WAIT && instr_done) begin
            push_data <= next_pc; // resume address goes first
        end else if (state == ITA_PUSH && core_ack) begin
            case (push_idx)
                PUSH_PC: push_data <= {24'h000000, save_ccr}; // then ccr
                default: push_data <= {24'h000000, save_exr}; // exr last
            endcase
        end
    end

    // vector number for the accepted exception
    // kinds share one register, settled long before the vector state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vec_num <= '0;
        end else if (is_trap) begin
            vec_num <= VEC_TRAP_BASE + VEC_W'(take_trap);
        end else if (is_nmi) begin
            vec_num <= VEC_NMI;
        end else begin
            vec_num <= VEC_IRQ_BASE + VEC_W'(take_src);
        end
    end

    // new ccr: mask bit set, user bit and rest retained
    // value tracks save_ccr; only the pulse tells the core to take it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            condition_code_reg <= '0;
            ccr_we <= 1'b0;
        end else begin
            ccr_we <= (state == ITA_VEC) && core_ack;
            condition_code_reg <= save_ccr | (8'h01 << CCR_I);
        end
    end

    // new exr: trace cleared in mode 2, mask per exception kind
    // mode 0 leaves exr alone, so no write pulse is raised there
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extended_control_reg <= '0;
            exr_we <= 1'b0;
        end else begin
            exr_we <= (state == ITA_VEC) && core_ack && (int_mode == MODE2);
            extended_control_reg <= save_exr & ~(8'h01 << EXR_T); // trace off
            if (is_nmi) begin
                extended_control_reg[LVL_W-1:0] <= LVL_MAX;
            end else if (!is_trap) begin
                extended_control_reg[LVL_W-1:0] <= take_lvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // handshake strobes may be combinational
    // they decode the registered state, so they rise in the same cycle that state is entered
    assign exc_busy = (state != ITA_IDLE);
    assign push_valid = (state == ITA_PUSH);
    assign vec_valid = (state == ITA_VEC);
    assign src_taken = clr_vec;
endmodule
`default_nettype wire

// ==== design/ita_pkg.sv ====
// ita_pkg: constants and types for the interrupt and trap acceptance unit
// assumes a 16-bit cpu core sequencer that drives the instruction stream
package ita_pkg;
    localparam int NUM_SRC = 8;                  // maskable sources
    localparam int LVL_W = 3;                    // mask and priority level width
    localparam logic [2:0] LVL_MAX = 3'h7;       // level forced by the non-maskable source
    localparam int TRAP_W = 2;                   // trap vector number width
    localparam int VEC_W = 8;                    // vector number width
    localparam logic [7:0] VEC_TRAP_BASE = 8'h08; // first trap vector slot
    localparam logic [7:0] VEC_NMI = 8'h07;      // non-maskable vector slot
    localparam logic [7:0] VEC_IRQ_BASE = 8'h10; // first maskable vector slot
    localparam logic [1:0] MODE0 = 2'h0;         // plain interrupt control mode
    localparam logic [1:0] MODE2 = 2'h2;         // eight-level interrupt control mode
    localparam int CCR_I = 7;                    // mask bit position in condition code reg
    localparam int CCR_UI = 6;                   // user mask bit position
    localparam int EXR_T = 7;                    // trace bit position in extended control reg
    localparam int PUSH_WORDS = 3;               // pc, ccr, exr pushed
    typedef enum logic [2:0] {
        ITA_IDLE = 3'h0,
        ITA_WAIT = 3'h1,
        ITA_PUSH = 3'h2,
        ITA_VEC = 3'h3,
        ITA_DONE = 3'h4
    } ita_state_type;
    typedef enum logic [1:0] {
        PUSH_PC = 2'h0,
        PUSH_CCR = 2'h1,
        PUSH_EXR = 2'h2
    } ita_push_type;
endpackage

// ==== design/ita_arb_if.sv ====
// ita_arb_if: carries pending requests and the arbiter's choice
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
interface ita_arb_if;
    import ita_pkg::*;
    logic [NUM_SRC-1:0] pend;            // gated pending requests
    logic [NUM_SRC*LVL_W-1:0] prio;      // programmed levels, packed
    logic found;                         // some request pending
    logic [$clog2(NUM_SRC)-1:0] win;     // selected source
    logic [LVL_W-1:0] win_lvl;           // its level
    modport top (output pend, output prio, input found, input win, input win_lvl);
    modport arb (input pend, input prio, output found, output win, output win_lvl);
endinterface
`default_nettype wire

// ==== design/ita_arbiter.sv ====
// ita_arbiter: picks the highest-level pending source, ties by index
// assumes levels are stable within the cycle; purely combinational
`timescale 1ns/100ps
`default_nettype none
module ita_arbiter
    import ita_pkg::*;
(
    // selection bundle
    ita_arb_if.arb arb
);
    // scan from highest index down so lower index wins ties
    always_comb begin
        arb.found = 1'b0;
        arb.win = '0;
        arb.win_lvl = '0;
        for (int i = NUM_SRC-1; i >= 0; i--) begin
            if (arb.pend[i] && (!arb.found || arb.prio[i*LVL_W +: LVL_W] >= arb.win_lvl)) begin
                arb.found = 1'b1; // highest level taken, others stay pending
                arb.win = ($clog2(NUM_SRC))'(i);
                arb.win_lvl = arb.prio[i*LVL_W +: LVL_W];
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/ita_src_model.sv ====
// ita_src_model: a peripheral that raises a one-cycle event per request
// assumes the bench drives src_req at the falling edge
`timescale 1ns/100ps
`default_nettype none
module ita_src_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bench request level and event pulse
    input wire logic [7:0] src_req,
    output logic [7:0] src_event
);
    logic [7:0] req_q; // request seen last edge
    ////////////////////////////////////////////////////////////////////////////////
    // edge detect, so a held request fires once only
    always_ff @(posedge clk) begin
        req_q <= sys_rst ? 8'h00 : src_req;
    end
    assign src_event = src_req & ~req_q;
endmodule
`default_nettype wire

// ==== bench/ita_top_sva.sv ====
// ita_top_sva: port-level timing checks for the acceptance unit
// assumes one clock domain with a synchronous reset
`timescale 1ns/100ps
`default_nettype none
module ita_top_sva
    import ita_pkg::*;
(
    // clock, reset, config
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] int_mode,
    input wire logic [NUM_SRC-1:0] src_enable,
    // core side
    input wire logic instr_done,
    input wire logic trap_always_instr,
    input wire logic core_ack,
    // outputs
    input wire logic exc_busy,
    input wire logic push_valid,
    input wire logic vec_valid,
    input wire logic [VEC_W-1:0] vec_num,
    input wire logic exr_we,
    input wire logic [7:0] extended_control_reg,
    input wire logic [NUM_SRC-1:0] src_taken
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_trap_starts: assert property (trap_always_instr && !exc_busy |=> exc_busy)
        else $error("trap not taken from idle");
    a_push_after_done: assert property ($rose(push_valid) |-> $past(instr_done))
        else $error("push before instruction end");
    a_push_holds: assert property (push_valid && !core_ack |=> push_valid)
        else $error("push dropped before ack");
    a_vec_holds: assert property (vec_valid && !core_ack |=> vec_valid && $stable(vec_num))
        else $error("vector dropped before ack");
    a_taken_onehot: assert property (src_taken != 8'h00 |-> $onehot(src_taken) && exc_busy)
        else $error("taken not one-hot");
    a_taken_enabled: assert property (src_taken != 8'h00 |-> (src_taken & ~src_enable) == 8'h00)
        else $error("disabled source taken");
    a_exr_mode_two: assert property (exr_we |-> int_mode == MODE2 && !extended_control_reg[EXR_T])
        else $error("exr write wrong");
    a_we_single: assert property (exr_we |=> !exr_we && !exc_busy)
        else $error("exr write not a pulse");
endmodule
`default_nettype wire
bind ita_top ita_top_sva u_sva (
    .clk(clk),
    .sys_rst(sys_rst),
    .int_mode(int_mode),
    .src_enable(src_enable),
    .instr_done(instr_done),
    .trap_always_instr(trap_always_instr),
    .core_ack(core_ack),
    .exc_busy(exc_busy),
    .push_valid(push_valid),
    .vec_valid(vec_valid),
    .vec_num(vec_num),
    .exr_we(exr_we),
    .extended_control_reg(extended_control_reg),
    .src_taken(src_taken)
);

// ==== bench/tb.sv ====
// tb: drives traps and requests, plays the core's push and vector handshake
// assumes the unit's hand-over timing; inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ita_pkg::*;
    logic clk, sys_rst, nmi_event, instr_done, trap_always_instr, core_ack;
    logic exc_busy, push_valid, vec_valid, ccr_we, exr_we;
    logic [1:0] int_mode, trap_vec_num;
    logic [NUM_SRC*LVL_W-1:0] interrupt_priority_reg;
    logic [7:0] src_enable, src_req, src_event, ccr_in, exr_in, src_taken;
    logic [7:0] vec_num, condition_code_reg, extended_control_reg;
    logic [31:0] next_pc, push_data;
    int n_errors, total_checks;
    ita_top u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .int_mode(int_mode),
        .interrupt_priority_reg(interrupt_priority_reg),
        .src_enable(src_enable),
        .src_event(src_event),
        .nmi_event(nmi_event),
        .instr_done(instr_done),
        .trap_always_instr(trap_always_instr),
        .trap_vec_num(trap_vec_num),
        .next_pc(next_pc),
        .ccr_in(ccr_in),
        .exr_in(exr_in),
        .core_ack(core_ack),
        .exc_busy(exc_busy),
        .push_valid(push_valid),
        .push_data(push_data),
        .vec_valid(vec_valid),
        .vec_num(vec_num),
        .ccr_we(ccr_we),
        .condition_code_reg(condition_code_reg),
        .exr_we(exr_we),
        .extended_control_reg(extended_control_reg),
        .src_taken(src_taken)
    );
    ita_src_model u_src (.clk(clk), .sys_rst(sys_rst), .src_req(src_req), .src_event(src_event));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    // bounded wait: 0 push, 1 vector, 2 write pulse, 3 busy
    task wsig(input int w);
        int k;
        k = 0;
        while (!(w == 0 ? push_valid : w == 1 ? vec_valid : w == 2 ? exr_we | ccr_we
                : exc_busy) && k < 50) begin
            @(negedge clk);
            k++;
        end
        if (k >= 50) begin
            n_errors++;
            give_verdict;
        end
    endtask
    // one full exception as the core sees it
    task exc(input logic [7:0] v, input logic [7:0] xe, input logic xc);
        wsig(3);
        repeat (3) @(negedge clk);
        cmp("push_early", 0, push_valid);
        cmp("taken", v >= VEC_IRQ_BASE ? 32'h1 << (v - VEC_IRQ_BASE) : 32'h0, src_taken);
        instr_done = 1'b1;
        @(negedge clk);
        instr_done = 1'b0;
        for (int i = 0; i < 3; i++) begin
            wsig(0);
            @(negedge clk);
            cmp("push", i == 0 ? next_pc : {24'h0, i == 1 ? ccr_in : exr_in},
                i == 0 ? push_data : {24'h0, push_data[7:0]});
            core_ack = 1'b1;
            @(negedge clk);
            core_ack = 1'b0;
        end
        wsig(1);
        cmp("vec", v, vec_num);
        core_ack = 1'b1;
        @(negedge clk);
        core_ack = 1'b0;
        wsig(2);
        cmp("exr_we", int_mode == MODE2, exr_we);
        cmp("ccr_we", 1, ccr_we);
        if (int_mode == MODE2) cmp("exr", xe, extended_control_reg);
        if (xc) cmp("ccr", 8'hc1, condition_code_reg);
        @(negedge clk);
    endtask
    // pulse a set of sources through the model
    task fire(input logic [7:0] m);
        src_req = m;
        repeat (2) @(negedge clk);
        src_req = 8'h00;
    endtask
    task quiet;
        repeat (5) @(negedge clk);
        cmp("busy", 0, exc_busy);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        {nmi_event, instr_done, trap_always_instr, core_ack} = 4'h0;
        int_mode = MODE2;
        interrupt_priority_reg = '0;
        src_enable = 8'hbf;
        src_req = 8'h00;
        trap_vec_num = 2'h0;
        next_pc = 32'h0000_1234;
        ccr_in = 8'h41;
        exr_in = 8'h85;
        n_errors = 0;
        total_checks = 0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        // every trap number, both control modes
        for (int m = 0; m < 2; m++) begin
            for (int n = 0; n < 4; n++) begin
                int_mode = m ? MODE0 : MODE2;
                trap_vec_num = n[1:0];
                trap_always_instr = 1'b1;
                @(negedge clk);
                trap_always_instr = 1'b0;
                exc(VEC_TRAP_BASE + n[7:0], 8'h05, 1'b1);
            end
        end
        // level equal to mask waits, then goes once mask drops
        int_mode = MODE2;
        exr_in = 8'h03;
        interrupt_priority_reg[8:6] = 3'h3;
        fire(8'h04);
        quiet;
        exr_in = 8'h02;
        exc(VEC_IRQ_BASE + 8'h02, 8'h03, 1'b0);
        // higher level first, lower one kept pending
        exr_in = 8'h80;
        interrupt_priority_reg[5:3] = 3'h5;
        interrupt_priority_reg[14:12] = 3'h6;
        fire(8'h12);
        exc(VEC_IRQ_BASE + 8'h04, 8'h06, 1'b0);
        exc(VEC_IRQ_BASE + 8'h01, 8'h05, 1'b0);
        // equal levels: lower index first
        interrupt_priority_reg[11:9] = 3'h4;
        interrupt_priority_reg[17:15] = 3'h4;
        fire(8'h28);
        exc(VEC_IRQ_BASE + 8'h03, 8'h04, 1'b0);
        exc(VEC_IRQ_BASE + 8'h05, 8'h04, 1'b0);
        // disabled source forwards nothing, not even later
        interrupt_priority_reg[20:18] = 3'h7;
        fire(8'h40);
        quiet;
        src_enable = 8'hff;
        quiet;
        // non-maskable forces the top level
        // pin level held long enough to pass the filter
        nmi_event = 1'b1;
        repeat (3) @(negedge clk);
        nmi_event = 1'b0;
        exc(VEC_NMI, 8'h07, 1'b0);
        // mode 0: ccr mask bit gates, levels ignored
        int_mode = MODE0;
        exr_in = 8'h87;
        ccr_in = 8'hc1;
        fire(8'h01);
        quiet;
        ccr_in = 8'h41;
        exc(VEC_IRQ_BASE, 8'h00, 1'b1);
        give_verdict;
    end
endmodule
`default_nettype wire
